// >>> pkg/black_level_regs.vh
// Constants for the black-level offset loop control block
`ifndef BLACK_LEVEL_REGS_VH
`define BLACK_LEVEL_REGS_VH
`define CAL_CYCLES        16'd40000
`define CLAMP_MIN         10'h00E
`define CLAMP_MAX         10'h04C
`define ADC_CENTRE_CODE   10'h200
`define ERR_LIMIT         11'h020
`define CODE_WIDTH        10
`define GAIN_WIDTH        8
`define CAL_INIT          10'h000
`define DAC_WIDTH         11
`endif

// >>> rtl/lead_in_timer.v
// Line counter that times the return from lead-in to normal loop gain
`timescale 1ns/1ps
module lead_in_timer
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       restart,
  input  wire       line_tick,
  input  wire       error_small,
  input  wire [1:0] stop_select,
  output reg        expired
);
  reg  [3:0] count;
  wire [3:0] limit = 4'h1 << stop_select;

  always @(posedge clk)
  begin
    if (!rst_n || restart)
    begin
      count   <= 4'h0;
      expired <= 1'b0;
    end
    else if (line_tick)
    begin
      // A large error restarts the count, so lead-in persists
      if (!error_small)
      begin
        count   <= 4'h0;
        expired <= 1'b0;
      end
      else if (count + 4'h1 >= limit)
      begin
        count   <= 4'h0;
        expired <= 1'b1;
      end
      else
      begin
        count   <= count + 4'h1;
        expired <= 1'b0;
      end
    end
    else
      expired <= 1'b0;
  end
endmodule // lead_in_timer

// >>> rtl/black_level_control.v
// Offset calibration, clamp, lead-in loop and output control
// Functional notes
// - Calibration starts when reset mode is released and ends after exactly 40000 clocks.
// - The offset DAC code is the calibration result plus the clamp level of 14 to 76 LSB plus the loop accumulator.
// - An eight-bit gain code sets the gain, log-linear from -2.36 dB in 0.132 dB steps.
// - In direct converter-input mode the centre level is clamped to code 512.
// - Offset is measured only during optical black, and one black-pulse period is one line.
// - A gain code change after calibration enters lead-in, where loop gain is multiplied by N.
// - The lead-in gain field selects N as 4, 8, 16 or 32.
// - Lead-in holds while error exceeds 32 LSB, then ends after the selected line count.
// - The lead-in stop field selects 1, 2, 4 or 8 lines.
// - Black level is sampled on the black pulse and signal on the signal pulse every pixel.
// - Preblanking suspends front-end sampling and input biasing.
// - Preblanking forces the output code to the clamp value.
// - The result is a ten-bit parallel output word.
`timescale 1ns/1ps
`include "black_level_regs.vh"
module black_level_control
(
  input  wire        CLOCK,
  input  wire        RESET_N,
  input  wire        RESET_MODE,
  input  wire        SENSOR_INPUT_MODE,
  input  wire [7:0]  GAIN_CODE,
  input  wire [9:0]  CLAMP_LEVEL,
  input  wire [1:0]  LEAD_IN_GAIN_SELECT,
  input  wire [1:0]  LEAD_IN_STOP_SELECT,
  input  wire        PREBLANK_IN,
  input  wire        OPTICAL_BLACK_PULSE,
  input  wire        BLACK_SAMPLE_PULSE,
  input  wire        SIGNAL_SAMPLE_PULSE,
  input  wire [9:0]  CONVERTER_DATA,
  output reg  [9:0]  SAMPLE_OUT_BITS,
  output reg  [10:0] OFFSET_DAC_CODE,
  output reg  [7:0]  AMP_GAIN_CODE,
  output reg  [5:0]  LOOP_GAIN_FACTOR,
  output reg  [10:0] OFFSET_ERROR,
  output reg         CALIBRATING,
  output reg         LEAD_IN_ACTIVE,
  output reg         BLACK_HOLD,
  output reg         SIGNAL_HOLD,
  output reg         INPUT_BIAS_ON
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_CAL   = 2'b01;
  localparam ST_RUN   = 2'b10;
  localparam ST_LEAD  = 2'b11;

  ////////////////////////////////////////////////////////////////////////////////
  // State and calibration
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [15:0] cal_count;
  reg  [9:0]  cal_result;
  reg         obp_prev;
  reg         gain_changed;
  reg  [10:0] acc;
  wire        line_tick = OPTICAL_BLACK_PULSE && !obp_prev;
  wire        restart   = RESET_MODE;
  wire        lead_done;
  reg  [10:0] next_acc;
  wire [9:0]  next_sample;
  wire        cal_last  = (cal_count == `CAL_CYCLES - 16'h0001);
  wire        measuring = (state == ST_RUN || state == ST_LEAD) && OPTICAL_BLACK_PULSE &&
                          !PREBLANK_IN;
  wire [9:0]  clamp_safe = (CLAMP_LEVEL < `CLAMP_MIN) ? `CLAMP_MIN :
                           (CLAMP_LEVEL > `CLAMP_MAX) ? `CLAMP_MAX : CLAMP_LEVEL;
  wire [9:0]  clamp_target = SENSOR_INPUT_MODE ? clamp_safe : `ADC_CENTRE_CODE;
  wire [10:0] signed_err = {1'b0, CONVERTER_DATA} - {1'b0, clamp_target};
  wire [10:0] abs_err = signed_err[10] ? (11'h000 - signed_err) : signed_err;
  wire        error_small = (abs_err <= `ERR_LIMIT);
  // Error scaled down before integration so the normal loop gain stays well below one
  wire [10:0] err_step  = {{6{signed_err[10]}}, signed_err[10:6]};
  wire [16:0] loop_prod = {6'h00, err_step} * {11'h000, LOOP_GAIN_FACTOR};
  wire [10:0] loop_step = loop_prod[10:0];

  lead_in_timer u_timer
  (
    .clk         (CLOCK),
    .rst_n       (RESET_N),
    .restart     (restart || gain_changed),
    .line_tick   (line_tick),
    .error_small (error_small),
    .stop_select (LEAD_IN_STOP_SELECT),
    .expired     (lead_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Mode sequence
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        next_state = ST_CAL;
      end
      ST_CAL:
      begin
        if (cal_last)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        // Gain changes during calibration are absorbed by the trim itself
        if (gain_changed)
          next_state = ST_LEAD;
      end
      ST_LEAD:
      begin
        // A new gain change in lead-in restarts the line count instead
        if (lead_done && !gain_changed)
          next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK)
  begin
    if (!RESET_N || restart)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always @(posedge CLOCK)
  begin
    if (!RESET_N || restart)
    begin
      obp_prev      <= 1'b0;
      gain_changed  <= 1'b0;
      AMP_GAIN_CODE <= 8'h00;
    end
    else
    begin
      obp_prev      <= OPTICAL_BLACK_PULSE;
      AMP_GAIN_CODE <= GAIN_CODE;
      gain_changed  <= (GAIN_CODE != AMP_GAIN_CODE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Offset calibration
  always @(posedge CLOCK)
  begin
    if (!RESET_N || restart)
    begin
      cal_count  <= 16'h0000;
      cal_result <= `CAL_INIT;
    end
    else if (state == ST_CAL)
    begin
      cal_count <= cal_count + 16'h0001;
      // Simple up/down trim: slow, but it cannot overshoot on a noisy reading
      if (CONVERTER_DATA > `ADC_CENTRE_CODE && cal_result != 10'h3FF)
        cal_result <= cal_result + 10'h001;
      else if (CONVERTER_DATA < `ADC_CENTRE_CODE && cal_result != 10'h000)
        cal_result <= cal_result - 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Black-level feedback loop
  always @*
  begin
    next_acc = acc;
    if (measuring)
      next_acc = acc - loop_step;
  end

  always @(posedge CLOCK)
  begin
    if (!RESET_N || restart)
      acc <= 11'h000;
    else
      acc <= next_acc;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output word, one multiplexer per bit
  genvar b;
  generate
    for (b = 0; b < `CODE_WIDTH; b = b + 1)
    begin : g_out_bit
      // Clamp-forced output hides the converter during blanking
      assign next_sample[b] = PREBLANK_IN ? clamp_safe[b] : CONVERTER_DATA[b];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      SAMPLE_OUT_BITS  <= 10'h000;
      OFFSET_DAC_CODE  <= 11'h000;
      OFFSET_ERROR     <= 11'h000;
    end
    else
    begin
      SAMPLE_OUT_BITS  <= next_sample;
      OFFSET_DAC_CODE  <= {1'b0, cal_result} + {1'b0, clamp_safe} + acc;
      if (line_tick)
        OFFSET_ERROR   <= abs_err;
    end
  end

  always @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      LOOP_GAIN_FACTOR <= 6'h01;
      CALIBRATING      <= 1'b0;
      LEAD_IN_ACTIVE   <= 1'b0;
    end
    else
    begin
      LOOP_GAIN_FACTOR <= (state == ST_LEAD) ? (6'h04 << LEAD_IN_GAIN_SELECT) : 6'h01;
      // Held low through reset mode, so no phantom start is reported
      CALIBRATING      <= !restart && (next_state == ST_CAL);
      LEAD_IN_ACTIVE   <= !restart && (next_state == ST_LEAD);
    end
  end

  always @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      BLACK_HOLD       <= 1'b0;
      SIGNAL_HOLD      <= 1'b0;
      INPUT_BIAS_ON    <= 1'b0;
    end
    else
    begin
      BLACK_HOLD       <= BLACK_SAMPLE_PULSE && !PREBLANK_IN;
      SIGNAL_HOLD      <= SIGNAL_SAMPLE_PULSE && !PREBLANK_IN;
      INPUT_BIAS_ON    <= BLACK_SAMPLE_PULSE && !PREBLANK_IN;
    end
  end
endmodule // black_level_control

// >>> tb/pixel_timing_model.sv
// Pixel timing source on the far side of the block
`timescale 1ns/1ps
module pixel_timing_model
(
  input  logic clk,
  output logic black_pulse = 1'b0,
  output logic signal_pulse = 1'b0
);
  // One pixel is two clocks, black first, so both holds get exercised
  always @(posedge clk)
  begin
    black_pulse  <= ~black_pulse;
    signal_pulse <= black_pulse;
  end
endmodule // pixel_timing_model

// >>> tb/black_level_monitor.sv
// Port checker for the black-level control block
`timescale 1ns/1ps
module black_level_monitor
(
  input logic       CLOCK,
  input logic       RESET_N,
  input logic       RESET_MODE,
  input logic       PREBLANK_IN,
  input logic       BLACK_SAMPLE_PULSE,
  input logic       SIGNAL_SAMPLE_PULSE,
  input logic [7:0] GAIN_CODE,
  input logic [9:0] CLAMP_LEVEL,
  input logic [9:0] CONVERTER_DATA,
  input logic [9:0] SAMPLE_OUT_BITS,
  input logic [7:0] AMP_GAIN_CODE,
  input logic       CALIBRATING,
  input logic       LEAD_IN_ACTIVE,
  input logic       BLACK_HOLD,
  input logic       SIGNAL_HOLD,
  input logic       INPUT_BIAS_ON
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  logic [16:0] cal_len;
  logic [9:0]  clamp_exp;
  // Clamp code saturated to its legal range of 14 to 76
  assign clamp_exp = (CLAMP_LEVEL < 10'h00E) ? 10'h00E :
                     (CLAMP_LEVEL > 10'h04C) ? 10'h04C : CLAMP_LEVEL;
  always @(posedge CLOCK) cal_len <= (RESET_N && CALIBRATING) ? cal_len + 17'h1 : 17'h0;
  property p_pb; PREBLANK_IN |=> SAMPLE_OUT_BITS == $past(clamp_exp); endproperty
  property p_dat; !PREBLANK_IN |=> SAMPLE_OUT_BITS == $past(CONVERTER_DATA); endproperty
  property p_off; PREBLANK_IN |=> !BLACK_HOLD && !INPUT_BIAS_ON; endproperty
  property p_blk; !PREBLANK_IN && BLACK_SAMPLE_PULSE |=> BLACK_HOLD && INPUT_BIAS_ON; endproperty
  property p_cal; $fell(RESET_MODE) |-> ##[1:2] CALIBRATING; endproperty
  property p_len; $fell(CALIBRATING) |-> cal_len == 17'h09C40; endproperty
  property p_rst; RESET_MODE |=> !CALIBRATING && !LEAD_IN_ACTIVE; endproperty
  property p_gain; !CALIBRATING && $changed(GAIN_CODE) |-> ##[1:3] LEAD_IN_ACTIVE; endproperty
  property p_sig; !PREBLANK_IN && SIGNAL_SAMPLE_PULSE |=> SIGNAL_HOLD; endproperty
  property p_amp; !RESET_MODE |=> AMP_GAIN_CODE == $past(GAIN_CODE); endproperty
  a_pb: assert property (p_pb) else $error("clamp");
  a_dat: assert property (p_dat) else $error("data");
  a_off: assert property (p_off) else $error("hold");
  a_blk: assert property (p_blk) else $error("black");
  a_cal: assert property (p_cal) else $error("start");
  a_len: assert property (p_len) else $error("length");
  a_rst: assert property (p_rst) else $error("restart");
  a_gain: assert property (p_gain) else $error("lead-in");
  a_sig: assert property (p_sig) else $error("signal");
  a_amp: assert property (p_amp) else $error("gain code");
  c_pb: cover property (PREBLANK_IN);
  c_cal: cover property ($fell(CALIBRATING));
  c_lead: cover property ($fell(LEAD_IN_ACTIVE));
endmodule // black_level_monitor

// >>> tb/tb_top.sv
// Self-checking bench for the black-level control block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic        CLOCK = 1'b0, RESET_N = 1'b0, RESET_MODE = 1'b1, PREBLANK_IN = 1'b0;
  logic        SENSOR_INPUT_MODE = 1'b1, OPTICAL_BLACK_PULSE = 1'b0;
  logic [7:0]  GAIN_CODE = 8'h00;
  logic [9:0]  CLAMP_LEVEL = 10'h020, CONVERTER_DATA = 10'h000;
  logic [1:0]  LEAD_IN_GAIN_SELECT = 2'h0, LEAD_IN_STOP_SELECT = 2'h0;
  wire         BLACK_SAMPLE_PULSE, SIGNAL_SAMPLE_PULSE, CALIBRATING, LEAD_IN_ACTIVE;
  wire         BLACK_HOLD, SIGNAL_HOLD, INPUT_BIAS_ON;
  wire  [9:0]  SAMPLE_OUT_BITS;
  wire  [10:0] OFFSET_DAC_CODE, OFFSET_ERROR;
  wire  [7:0]  AMP_GAIN_CODE;
  wire  [5:0]  LOOP_GAIN_FACTOR;
  int          fail_count = 0, total_checks = 0, n;
  logic [30:0] rows [6] = '{{1'b0, 10'h3FF, 10'h020, 10'h3FF}, {1'b1, 10'h3FF, 10'h00E, 10'h00E},
    {1'b1, 10'h2AA, 10'h005, 10'h00E}, {1'b1, 10'h2AA, 10'h3FF, 10'h04C},
    {1'b1, 10'h155, 10'h04C, 10'h04C}, {1'b0, 10'h155, 10'h04C, 10'h155}};
  black_level_control i_dut
  (
    .CLOCK               (CLOCK),
    .RESET_N             (RESET_N),
    .RESET_MODE          (RESET_MODE),
    .SENSOR_INPUT_MODE   (SENSOR_INPUT_MODE),
    .GAIN_CODE           (GAIN_CODE),
    .CLAMP_LEVEL         (CLAMP_LEVEL),
    .LEAD_IN_GAIN_SELECT (LEAD_IN_GAIN_SELECT),
    .LEAD_IN_STOP_SELECT (LEAD_IN_STOP_SELECT),
    .PREBLANK_IN         (PREBLANK_IN),
    .OPTICAL_BLACK_PULSE (OPTICAL_BLACK_PULSE),
    .BLACK_SAMPLE_PULSE  (BLACK_SAMPLE_PULSE),
    .SIGNAL_SAMPLE_PULSE (SIGNAL_SAMPLE_PULSE),
    .CONVERTER_DATA      (CONVERTER_DATA),
    .SAMPLE_OUT_BITS     (SAMPLE_OUT_BITS),
    .OFFSET_DAC_CODE     (OFFSET_DAC_CODE),
    .AMP_GAIN_CODE       (AMP_GAIN_CODE),
    .LOOP_GAIN_FACTOR    (LOOP_GAIN_FACTOR),
    .OFFSET_ERROR        (OFFSET_ERROR),
    .CALIBRATING         (CALIBRATING),
    .LEAD_IN_ACTIVE      (LEAD_IN_ACTIVE),
    .BLACK_HOLD          (BLACK_HOLD),
    .SIGNAL_HOLD         (SIGNAL_HOLD),
    .INPUT_BIAS_ON       (INPUT_BIAS_ON)
  );
  pixel_timing_model i_model (.clk(CLOCK), .black_pulse(BLACK_SAMPLE_PULSE),
    .signal_pulse(SIGNAL_SAMPLE_PULSE));
  task automatic tick(input int k);
    repeat (k) @(posedge CLOCK);
  endtask
  task automatic ob_line();
    OPTICAL_BLACK_PULSE <= 1'b1;
    tick(4);
    OPTICAL_BLACK_PULSE <= 1'b0;
    tick(4);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #20 CLOCK = ~CLOCK;
  initial
  begin
    tick(5);
    RESET_N <= 1'b1;
    tick(1);
    RESET_MODE <= 1'b0;
    tick(3);
    for (n = 0; CALIBRATING === 1'b1 && n < 41000; n++) tick(1);
    `CHK(n > 39990 && n < 40002, 1'b1)
    $display("calibration test done");
    foreach (rows[i])
    begin
      {PREBLANK_IN, CONVERTER_DATA, CLAMP_LEVEL} <= rows[i][30:10];
      tick(2);
      `CHK(SAMPLE_OUT_BITS, rows[i][9:0])
    end
    $display("output code test done");
    for (int g = 0; g < 4; g++)
    begin
      {LEAD_IN_GAIN_SELECT, LEAD_IN_STOP_SELECT, CONVERTER_DATA} <= {g[1:0], g[1:0], 10'h04C};
      tick(2);
      GAIN_CODE <= GAIN_CODE + 8'h11;
      tick(4);
      `CHK({LEAD_IN_ACTIVE, LOOP_GAIN_FACTOR}, {1'b1, 6'h04 << g})
      `CHK(AMP_GAIN_CODE, GAIN_CODE)
      for (n = 0; LEAD_IN_ACTIVE === 1'b1 && n < 20; n++) ob_line();
      `CHK(n >= (1 << g) && n <= (1 << g) + 1, 1'b1)
      `CHK(LOOP_GAIN_FACTOR, 6'h01)
    end
    $display("lead-in release test done");
    CONVERTER_DATA <= 10'h0B0;
    GAIN_CODE <= 8'h00;
    repeat (12) ob_line();
    `CHK(LEAD_IN_ACTIVE, 1'b1)
    `CHK(OFFSET_ERROR, 11'h064)
    $display("large error test done");
    SENSOR_INPUT_MODE <= 1'b0;
    CONVERTER_DATA <= 10'h210;
    ob_line();
    `CHK(OFFSET_ERROR, 11'h010)
    $display("direct mode test done");
    SENSOR_INPUT_MODE <= 1'b1;
    CONVERTER_DATA <= 10'h100;
    RESET_MODE <= 1'b1;
    tick(3);
    `CHK({CALIBRATING, LEAD_IN_ACTIVE}, 2'b00)
    RESET_MODE <= 1'b0;
    tick(4);
    `CHK({CALIBRATING, LOOP_GAIN_FACTOR, OFFSET_DAC_CODE}, {1'b1, 6'h01, 11'h04C})
    $display("restart test done");
    end_sim();
  end
endmodule // tb_top
bind black_level_control black_level_monitor i_mon
(
  .CLOCK               (CLOCK),
  .RESET_N             (RESET_N),
  .RESET_MODE          (RESET_MODE),
  .PREBLANK_IN         (PREBLANK_IN),
  .BLACK_SAMPLE_PULSE  (BLACK_SAMPLE_PULSE),
  .SIGNAL_SAMPLE_PULSE (SIGNAL_SAMPLE_PULSE),
  .GAIN_CODE           (GAIN_CODE),
  .CLAMP_LEVEL         (CLAMP_LEVEL),
  .CONVERTER_DATA      (CONVERTER_DATA),
  .SAMPLE_OUT_BITS     (SAMPLE_OUT_BITS),
  .AMP_GAIN_CODE       (AMP_GAIN_CODE),
  .CALIBRATING         (CALIBRATING),
  .LEAD_IN_ACTIVE      (LEAD_IN_ACTIVE),
  .BLACK_HOLD          (BLACK_HOLD),
  .SIGNAL_HOLD         (SIGNAL_HOLD),
  .INPUT_BIAS_ON       (INPUT_BIAS_ON)
);
